// ==== design/tcd_device.sv ====
// Purpose: Decodes per-buffer command words and strips data to a byte stream.
// Assumes: Words arrive as command A, command B, then the buffer data words.
// Notes: One byte lane is examined per cycle; throughput is traded for size.
// Summary of operation
// - Bits 20:16 of A give start offset.
// - A bit 13 marks first segment.
// - A bit 12 marks last segment.
// - Host puts buffer byte count in A 10:0.
// - Offset plus size plus alignment gives padded word count.
// - Sum sizes; mismatch with length sets error.
// - Tag from B 31:16 goes to status.
// - Tag content is never interpreted.
// - Checksum needs B bit 14, first, enable.
// - B bit 13 suppresses CRC append.
// - B bit 12 suppresses short frame padding.
// - Padding disabled still forces CRC append.
// - Host puts packet length in B 10:0.
// - Lengths exclude offset and alignment padding.
// - Host writes zero to reserved bits.
// - Differing B words within packet set error.
// - A 25:24 selects 4, 16, 32 alignment.
// - A bit 31 pulses loaded after buffer.
// - Offset low bits pick lane, upper skip words.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
module tcd_device
	import tcd_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	tcd_link_if.dev LINK,
	input wire logic I_CHECKSUM_ENGINE_ENABLE,
	input wire logic I_MAC_READY,
	output logic O_MAC_VALID,
	output logic [7:0] O_MAC_DATA,
	output logic O_MAC_LAST,
	output logic O_PKT_CHECKSUM,
	output logic O_PKT_ADD_CRC,
	output logic O_PKT_PAD,
	output logic O_STATUS_VALID,
	output logic [15:0] O_STATUS_TAG,
	output logic O_TRANSMIT_ERROR_FLAG
);
	typedef struct packed {
		tcd_phase_t phase;
		logic [4:0] off;
		logic [10:0] size;
		logic fs;
		logic ls;
		logic ioc;
		logic [10:0] words_total;
		logic [10:0] wcnt;
		logic [31:0] cmdb;
		logic [11:0] sum;
		logic [31:0] word;
		logic hold;
		logic [1:0] lane;
		logic out_valid;
		logic [7:0] out_byte;
		logic out_last;
		logic cks;
		logic add_crc;
		logic pad;
		logic stat_valid;
		logic [15:0] stat_tag;
		logic loaded;
		logic err;
	} tcd_dev_state_t;

	tcd_dev_state_t q;
	tcd_dev_state_t d;

	logic [12:0] bpos;
	logic [12:0] range_end;
	logic in_range;
	logic slot_free;
	logic end_buf;
	logic err_set;
	logic [12:0] raw_words;
	logic [12:0] amask;
	logic [12:0] aligned;
	logic [4:0] a_off;
	logic [10:0] a_size;
	logic [31:0] shifted;

	////////////////////////////////////////////////////////////////////////////
	// Layout arithmetic for the command word being offered
	always_comb begin
		a_off = LINK.word_data[CA_OFF_LO +: 5];
		a_size = LINK.word_data[10:0];
		raw_words = ({8'h00, a_off} + {2'h0, a_size} + 13'h0003) >> 2;
		case (LINK.word_data[CA_ALIGN_LO +: 2])
			ALIGN_4: amask = AMASK_4;
			ALIGN_16: amask = AMASK_16;
			ALIGN_32: amask = AMASK_32;
			// Reserved code: treated as 4-byte so the stream never hangs
			default: amask = AMASK_4;
		endcase
		aligned = (raw_words + amask) & ~amask;
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte position of the lane under examination
	always_comb begin
		bpos = {q.wcnt, q.lane};
		range_end = {8'h00, q.off} + {2'h0, q.size};
		in_range = (bpos >= {8'h00, q.off}) && (bpos < range_end);
		shifted = q.word >> {q.lane, 3'b000};
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.loaded = 1'b0;
		d.stat_valid = 1'b0;
		end_buf = 1'b0;
		err_set = 1'b0;
		if (q.out_valid && I_MAC_READY) begin
			d.out_valid = 1'b0;
		end
		slot_free = !q.out_valid || I_MAC_READY;
		case (q.phase)
			TCD_CMD_A: begin
				if (LINK.word_valid) begin
					d.off = a_off;
					d.size = a_size;
					d.fs = LINK.word_data[CA_FS];
					d.ls = LINK.word_data[CA_LS];
					d.ioc = LINK.word_data[CA_IOC];
					d.words_total = aligned[10:0];
					d.phase = TCD_CMD_B;
				end
			end
			TCD_CMD_B: begin
				if (LINK.word_valid) begin
					d.cmdb = LINK.word_data;
					d.wcnt = 11'h000;
					if (q.fs) begin
						d.sum = {1'b0, q.size};
						d.cks = LINK.word_data[CB_CKS] && I_CHECKSUM_ENGINE_ENABLE;
						d.add_crc = !LINK.word_data[CB_NOCRC] || LINK.word_data[CB_NOPAD];
						d.pad = !LINK.word_data[CB_NOPAD];
					end else begin
						d.sum = q.sum + {1'b0, q.size};
						if (LINK.word_data != q.cmdb) begin
							err_set = 1'b1;
						end
					end
					if (q.words_total == 11'h000) begin
						end_buf = 1'b1;
					end else begin
						d.phase = TCD_DATA;
					end
				end
			end
			TCD_DATA: begin
				if (!q.hold) begin
					if (LINK.word_valid) begin
						d.word = LINK.word_data;
						d.hold = 1'b1;
						d.lane = 2'h0;
					end
				end else if (!in_range || slot_free) begin
					// Bytes outside the window are dropped without a MAC beat
					if (in_range) begin
						d.out_valid = 1'b1;
						d.out_byte = shifted[7:0];
						d.out_last = q.ls && (bpos == range_end - 13'h0001);
					end
					d.lane = q.lane + 2'h1;
					if (q.lane == 2'h3) begin
						d.hold = 1'b0;
						d.wcnt = q.wcnt + 11'h001;
						if (d.wcnt == q.words_total) begin
							end_buf = 1'b1;
						end
					end
				end
			end
			default: d.phase = TCD_CMD_A;
		endcase
		if (end_buf) begin
			d.phase = TCD_CMD_A;
			d.loaded = d.ioc;
			if (d.ls) begin
				if (d.sum != {1'b0, d.cmdb[10:0]}) begin
					err_set = 1'b1;
				end
				d.stat_valid = 1'b1;
				// Passed through untouched; duplicates are legal
				d.stat_tag = d.cmdb[CB_TAG_LO +: 16];
			end
		end
		// Set beats a clear arriving in the same cycle
		if (err_set) begin
			d.err = 1'b1;
		end else if (LINK.err_clear) begin
			d.err = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign LINK.word_ready = (q.phase != TCD_DATA) || !q.hold;
	assign LINK.err_flag = q.err;
	assign LINK.loaded = q.loaded;
	assign O_MAC_VALID = q.out_valid;
	assign O_MAC_DATA = q.out_byte;
	assign O_MAC_LAST = q.out_last;
	assign O_PKT_CHECKSUM = q.cks;
	assign O_PKT_ADD_CRC = q.add_crc;
	assign O_PKT_PAD = q.pad;
	assign O_STATUS_VALID = q.stat_valid;
	assign O_STATUS_TAG = q.stat_tag;
	assign O_TRANSMIT_ERROR_FLAG = q.err;
endmodule : tcd_device

// ==== design/tcd_host.sv ====
// Purpose: Host end: software writes command and data words over AXI4-Lite.
// Assumes: Software supplies sizes and lengths that exclude offset and padding.
// Notes: One word is held at a time; writes stall on the bus until it drains.
module tcd_host
	import tcd_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	tcd_link_if.host LINK,
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	input wire logic [ADDR_W-1:0] I_AXI_AWADDR,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	output logic [1:0] O_AXI_BRESP,
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	input wire logic [ADDR_W-1:0] I_AXI_ARADDR,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP
);
	if (ADDR_W < 4) begin : g_chk
		$error("ADDR_W must be at least 4");
	end

	typedef struct packed {
		logic aw_have;
		logic [3:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic pend;
		logic [31:0] pword;
		logic err_clr;
		logic loaded_seen;
	} tcd_host_state_t;

	tcd_host_state_t q;
	tcd_host_state_t d;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.err_clr = 1'b0;
		if (q.pend && LINK.word_ready) begin
			d.pend = 1'b0;
		end
		if (I_AXI_AWVALID && !q.aw_have) begin
			d.aw_have = 1'b1;
			d.aw_addr = I_AXI_AWADDR[3:0];
			// Addresses beyond the map fold onto a misaligned code so they answer SLVERR
			if ((I_AXI_AWADDR >> 4) != '0) begin
				d.aw_addr = 4'h1;
			end
		end
		if (I_AXI_WVALID && !q.w_have) begin
			d.w_have = 1'b1;
			// Partial strobes are taken as full words; the link has no lanes
			d.w_data = I_AXI_WDATA;
		end
		if (q.bvalid && I_AXI_BREADY) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_have && q.w_have && !q.bvalid && !q.pend) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			case (q.aw_addr)
				REG_CMD_A: begin
					d.pend = 1'b1;
					// Size field passes as software wrote it
					d.pword = q.w_data & CA_KEEP_MASK;
				end
				REG_CMD_B: begin
					d.pend = 1'b1;
					d.pword = q.w_data & CB_KEEP_MASK;
				end
				REG_DATA: begin
					d.pend = 1'b1;
					d.pword = q.w_data;
				end
				REG_STATUS: begin
					d.err_clr = q.w_data[ST_ERR];
					if (q.w_data[ST_LOADED]) begin
						d.loaded_seen = 1'b0;
					end
				end
				default: d.bresp = RESP_SLVERR;
			endcase
		end
		// Set beats a software clear in the same cycle
		if (LINK.loaded) begin
			d.loaded_seen = 1'b1;
		end
		if (q.rvalid && I_AXI_RREADY) begin
			d.rvalid = 1'b0;
		end
		if (I_AXI_ARVALID && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			d.rdata = RESET_WORD;
			case (I_AXI_ARADDR[3:0])
				REG_STATUS: begin
					d.rdata[ST_PEND] = q.pend;
					d.rdata[ST_ERR] = LINK.err_flag;
					d.rdata[ST_LOADED] = q.loaded_seen;
				end
				REG_CMD_A, REG_CMD_B, REG_DATA: d.rdata = RESET_WORD;
				default: d.rresp = RESP_SLVERR;
			endcase
			// Upper address bits must not alias onto the four registers
			if ((I_AXI_ARADDR >> 4) != '0) begin
				d.rresp = RESP_SLVERR;
				d.rdata = RESET_WORD;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign LINK.word_valid = q.pend;
	assign LINK.word_data = q.pword;
	assign LINK.err_clear = q.err_clr;
	assign O_AXI_AWREADY = !q.aw_have;
	assign O_AXI_WREADY = !q.w_have;
	assign O_AXI_BVALID = q.bvalid;
	assign O_AXI_BRESP = q.bresp;
	assign O_AXI_ARREADY = !q.rvalid;
	assign O_AXI_RVALID = q.rvalid;
	assign O_AXI_RDATA = q.rdata;
	assign O_AXI_RRESP = q.rresp;
endmodule : tcd_host

// ==== design/tcd_link_if.sv ====
// Purpose: Word link between the host end and the decoder end.
// Assumes: Single clock; word moves when valid and ready are both high.
// Notes: Error flag is a level, loaded and clear are one-cycle pulses.
interface tcd_link_if;
	logic word_valid;
	logic word_ready;
	logic [31:0] word_data;
	logic err_flag;
	logic loaded;
	logic err_clear;

	modport dev (
		input word_valid, word_data, err_clear,
		output word_ready, err_flag, loaded
	);
	modport host (
		output word_valid, word_data, err_clear,
		input word_ready, err_flag, loaded
	);
endinterface : tcd_link_if

// ==== design/tcd_pkg.sv ====
// Purpose: Shared constants and types of the transmit command word decoder.
// Assumes: One 32-bit word moves per link handshake.
// Notes: Command word A carries buffer layout, command word B packet controls.
package tcd_pkg;
	// Command word A fields
	localparam int CA_IOC = 31;
	localparam int CA_ALIGN_LO = 24;
	localparam int CA_OFF_LO = 16;
	localparam int CA_FS = 13;
	localparam int CA_LS = 12;
	// Command word B fields
	localparam int CB_TAG_LO = 16;
	localparam int CB_CKS = 14;
	localparam int CB_NOCRC = 13;
	localparam int CB_NOPAD = 12;
	// Reserved positions are forced to zero with these masks
	localparam logic [31:0] CA_KEEP_MASK = 32'h831F_37FF;
	localparam logic [31:0] CB_KEEP_MASK = 32'hFFFF_77FF;
	// End alignment codes and word masks
	localparam logic [1:0] ALIGN_4 = 2'h0;
	localparam logic [1:0] ALIGN_16 = 2'h1;
	localparam logic [1:0] ALIGN_32 = 2'h2;
	localparam logic [12:0] AMASK_4 = 13'h0000;
	localparam logic [12:0] AMASK_16 = 13'h0003;
	localparam logic [12:0] AMASK_32 = 13'h0007;
	// Host register map (byte addresses)
	localparam logic [3:0] REG_CMD_A = 4'h0;
	localparam logic [3:0] REG_CMD_B = 4'h4;
	localparam logic [3:0] REG_DATA = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam int ST_PEND = 0;
	localparam int ST_ERR = 1;
	localparam int ST_LOADED = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {TCD_CMD_A, TCD_CMD_B, TCD_DATA} tcd_phase_t;
endpackage : tcd_pkg

// ==== dv/tcd_link_props.sv ====
// Purpose: Link checks between the host end and the decoder end.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Sees only the link signals, never the AXI or MAC sides.
module tcd_link_props (
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	input wire logic word_valid,
	input wire logic word_ready,
	input wire logic [31:0] word_data,
	input wire logic err_flag,
	input wire logic loaded,
	input wire logic err_clear
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RESETN);
	////////////////////////////////////////////////////////////////////////////
	valid_hold_a: assert property (word_valid && !word_ready |=> word_valid)
		else $error("word withdrawn before taken");
	data_stable_a: assert property (word_valid && !word_ready |=> $stable(word_data))
		else $error("word changed while offered");
	loaded_pulse_a: assert property (loaded |=> !loaded)
		else $error("loaded longer than one cycle");
	loaded_idle_a: assert property (loaded |-> word_ready)
		else $error("loaded while buffer still splitting");
	err_sticky_a: assert property (err_flag && !err_clear |=> err_flag)
		else $error("error flag dropped without clear");
	err_fall_a: assert property ($fell(err_flag) |-> $past(err_clear))
		else $error("error flag fell without clear");
	clear_pulse_a: assert property (err_clear |=> !err_clear)
		else $error("clear longer than one cycle");
	// Bounded because the bench stalls the MAC only every other cycle
	ready_back_a: assert property (!word_ready |-> ##[1:100] word_ready)
		else $error("link stuck not ready");
	cover property (loaded);
	cover property ($rose(err_flag));
	cover property (word_valid && !word_ready);
endmodule : tcd_link_props

// ==== dv/testbench.sv ====
// Purpose: Drives the host end over AXI4-Lite and checks the MAC byte stream.
// Assumes: MAC side takes a byte only every other cycle.
// Notes: Data byte value equals base plus its position in the buffer.
module testbench;
	import tcd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rstn = 1'b0, en = 1'b0, mrdy = 1'b0;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [4:0] awa = 5'h00, ara = 5'h00;
	logic [31:0] wd = 32'h0, rd;
	logic awr, wr, bv, arr, rv, mv, ml, ck, crc, pad, sv, te, lst;
	logic [1:0] bresp, rresp;
	logic [7:0] md;
	logic [15:0] tag;
	logic [7:0] q[$];
	int errors = 0, samples_checked = 0, nload = 0, nst = 0;
	tcd_link_if link();
	tcd_host #(.ADDR_W(5)) tcd_host_i (.I_REF_CLK(clk), .I_RESETN(rstn), .LINK(link),
		.I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_AWADDR(awa), .I_AXI_WVALID(wv),
		.O_AXI_WREADY(wr), .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hF), .O_AXI_BVALID(bv),
		.I_AXI_BREADY(br), .O_AXI_BRESP(bresp), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
		.I_AXI_ARADDR(ara), .O_AXI_RVALID(rv), .I_AXI_RREADY(rr), .O_AXI_RDATA(rd),
		.O_AXI_RRESP(rresp));
	tcd_device tcd_device_i (.I_REF_CLK(clk), .I_RESETN(rstn), .LINK(link),
		.I_CHECKSUM_ENGINE_ENABLE(en), .I_MAC_READY(mrdy), .O_MAC_VALID(mv),
		.O_MAC_DATA(md), .O_MAC_LAST(ml), .O_PKT_CHECKSUM(ck), .O_PKT_ADD_CRC(crc),
		.O_PKT_PAD(pad), .O_STATUS_VALID(sv), .O_STATUS_TAG(tag),
		.O_TRANSMIT_ERROR_FLAG(te));
	tcd_link_props tcd_link_props_i (.I_REF_CLK(clk), .I_RESETN(rstn),
		.word_valid(link.word_valid), .word_ready(link.word_ready),
		.word_data(link.word_data), .err_flag(link.err_flag), .loaded(link.loaded),
		.err_clear(link.err_clear));
	////////////////////////////////////////////////////////////////////////////
	always #2 clk = ~clk;
	always @(posedge clk) begin
		mrdy <= !mrdy;
		if (mv && mrdy) begin
			q.push_back(md);
			lst = ml;
		end
		if (link.loaded) nload++;
		if (sv) nst++;
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic got;
		n = 0;
		got = 1'b0;
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		br <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			got = bv;
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!got && n < 300);
		br <= 1'b0;
		chk("bvalid", 32'(got), 32'h1);
		chk("bresp", 32'(bresp), 32'(er));
	endtask : axw
	task automatic axr(input logic [4:0] a, output logic [31:0] d);
		int n;
		logic got;
		n = 0;
		got = 1'b0;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			got = rv;
			if (arr) arv <= 1'b0;
		end while (!got && n < 300);
		rr <= 1'b0;
		d = rd;
		chk("rvalid", 32'(got), 32'h1);
		chk("rresp", 32'(rresp), 32'(RESP_OKAY));
	endtask : axr
	task automatic sbuf(input logic [31:0] a, input logic [31:0] b, input int nw,
		input logic [7:0] base);
		logic [7:0] v;
		axw({1'b0, REG_CMD_A}, a, RESP_OKAY);
		axw({1'b0, REG_CMD_B}, b, RESP_OKAY);
		for (int i = 0; i < nw; i++) begin
			v = base + 8'(4 * i);
			axw({1'b0, REG_DATA}, {v + 8'h3, v + 8'h2, v + 8'h1, v}, RESP_OKAY);
		end
	endtask : sbuf
	// Waits on cumulative loaded and status counts and on the bytes together
	task automatic expb(input logic [7:0] first, input int sz, input int ld, input int st);
		int n;
		n = 0;
		while ((nload < ld || nst < st || q.size() < sz) && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk("byte count", 32'(q.size()), 32'(sz));
		chk("loaded count", 32'(nload), 32'(ld));
		chk("status count", 32'(nst), 32'(st));
		for (int i = 0; i < q.size(); i++) chk("byte", 32'(q[i]), 32'(first + 8'(i)));
		q.delete();
	endtask : expb
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////////
	// Offset 5, size 6, 16-byte end alignment: three words padded to four
	task automatic s_single();
		en <= 1'b1;
		sbuf(32'h8105_3006, 32'hA5C3_4006, 4, 8'h10);
		expb(8'h15, 6, 1, 1);
		chk("tag", 32'(tag), 32'h0000_A5C3);
		chk("last", 32'(lst), 32'h1);
		chk("csum", 32'(ck), 32'h1);
		chk("crc", {crc, pad, te}, 3'b110);
	endtask : s_single
	// Two segments whose sizes sum to 8 against a length of 9
	task automatic s_split();
		logic [31:0] r;
		en <= 1'b0;
		sbuf(32'h8003_2005, 32'h0000_6009, 2, 8'h40);
		expb(8'h43, 5, 2, 1);
		chk("mid last", 32'(lst), 32'h0);
		chk("early err", 32'(te), 32'h0);
		sbuf(32'h8200_1003, 32'h0000_6009, 8, 8'h80);
		expb(8'h80, 3, 3, 2);
		chk("err", 32'(te), 32'h1);
		chk("csum", 32'(ck), 32'h0);
		chk("crc", {crc, pad}, 2'b01);
		chk("tag", 32'(tag), 32'h0);
		axr({1'b0, REG_STATUS}, r);
		chk("status err", 32'(r[ST_ERR]), 32'h1);
		axw({1'b0, REG_STATUS}, 32'h0000_0006, RESP_OKAY);
		axr({1'b0, REG_STATUS}, r);
		chk("status clr", {30'h0, r[ST_LOADED], r[ST_ERR]}, 32'h0);
		axr({1'b0, REG_CMD_A}, r);
		chk("cmd read", r, RESET_WORD);
		axw(5'h10, 32'hFFFF_FFFF, RESP_SLVERR);
	endtask : s_split
	// Reserved bits set by software must not shift size; B words differ
	task automatic s_mismatch();
		en <= 1'b1;
		sbuf(32'hC0E0_E804, 32'h1234_B808, 1, 8'h20);
		expb(8'h20, 4, 4, 2);
		sbuf(32'h8002_1004, 32'h1235_3008, 2, 8'h30);
		expb(8'h32, 4, 5, 3);
		chk("err", 32'(te), 32'h1);
		chk("crc", {crc, pad, ck}, 3'b100);
		chk("tag", 32'(tag), 32'h0000_1235);
	endtask : s_mismatch
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		s_single();
		s_split();
		s_mismatch();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		test_done();
	end
endmodule : testbench
